// >>> rtl/mpc_panel.sv
// Maintenance panel control: displays, manual entry, run control, errors, timer.
// Assumes panel pins are asynchronous and the core and memory share sys_clk.
`timescale 1ns/1ps
`default_nettype none

module mpc_panel
  import mpc_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Panel pins
  input  wire mpc_btn_t          panel_btn,
  input  wire mpc_sw_t           panel_sw,
  // Panel indicators
  output logic [WORD_W-1:0]      disp_word,
  output logic [PC_W-1:0]        disp_pc,
  output logic [IR_W-1:0]        disp_ir,
  output logic [OPR_W-1:0]       disp_oper,
  output logic                   mar_par_led,
  output logic                   int_par_led,
  output logic                   ifc_err_led,
  output logic                   tmr_err_led,
  output logic                   running,
  // Core memory port
  output mpc_mem_t               mem_o,
  input  wire logic              mem_ack,
  input  wire logic [WORD_W-1:0] mem_rdata,
  // Processor core
  output logic                   cpu_go,
  output logic                   cpu_fetch,
  input  wire logic              cpu_done,
  input  wire logic              cpu_halt,
  input  wire logic [PC_W-1:0]   cpu_pc_next,
  input  wire logic [IR_W-1:0]   cpu_ir_next,
  input  wire logic              core_par_err,
  input  wire logic              io_par_err,
  // Interrupts
  input  wire logic              int_req,
  input  wire logic [15:0]       int_cause,
  input  wire logic              int_reenable,
  // Interval timer access
  input  wire logic              tmr_load,
  input  wire logic [TMR_W-1:0]  tmr_din,
  output logic [TMR_W-1:0]       tmr_value
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    mpc_btn_t                     b1;
    mpc_btn_t                     b2;
    mpc_btn_t                     b3;
    mpc_sw_t                      s1;
    mpc_sw_t                      s2;
    mpc_st_t                      st;
    logic                         run;
    logic                         fetch;
    logic                         go;
    logic                         mwe;
    logic [1:0]                   mdst;
    logic [NWREG-1:0][WORD_W-1:0] wreg;
    logic [PC_W-1:0]              pc;
    logic [IR_W-1:0]              ir;
    logic [NOPR-1:0][OPR_W-1:0]   oper;
    logic [TMR_W-1:0]             timer;
    logic                         int_par;
    logic                         ifc_err;
    logic                         tmr_err;
    logic                         par_ind;
    logic                         int_en;
  } mpc_state_t;

  mpc_state_t       q;
  mpc_state_t       d;
  mpc_btn_t         p;
  mpc_sw_t          sw;
  logic [1:0]       rst_s;
  logic             rst_n;
  logic             rd_bad;
  logic             int_evt;
  logic             tmr_zero;
  logic             osel_ok;
  logic [PC_W-1:0]  wfield;
  logic [31:0]      save_word;

  // ****************************************************************
  // Reset release
  // ****************************************************************

  // Reset asserts at once and releases two clocks later.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s <= 2'h0;
    end else begin
      rst_s <= {rst_s[0], 1'b1};
    end
  end
  assign rst_n = rst_s[1];

  // ****************************************************************
  // Decoded terms
  // ****************************************************************

  // Button pulses come from the second and third stages only.
  assign p         = mpc_btn_t'(q.b2 & ~q.b3);
  assign sw        = q.s2;
  assign wfield    = q.ir[WF_MSB:WF_LSB];
  assign osel_ok   = (q.s2.osel < 4'hc);
  assign rd_bad    = (q.st == ST_MEM) && mem_ack && !q.mwe && !(^mem_rdata);
  assign int_evt   = rd_bad | core_par_err;
  assign tmr_zero  = !tmr_load && (q.timer == TMR_ONE);
  assign save_word = {q.pc, int_cause};

  // ****************************************************************
  // Next state
  // ****************************************************************

  // All panel, run and error behaviour is computed here.
  always_comb begin
    d    = q;
    d.go = 1'b0;
    d.b1 = panel_btn;
    d.b2 = q.b1;
    d.b3 = q.b2;
    d.s1 = panel_sw;
    d.s2 = q.s1;

    // The timer counts every clock unless software presets it.
    if (tmr_load) begin
      d.timer = tmr_din;
    end else begin
      d.timer = q.timer - TMR_ONE;
    end

    // Error flags: a new event wins over a clear in the same cycle.
    if (p.eclr) begin
      d.int_par = 1'b0;
      d.ifc_err = 1'b0;
      d.tmr_err = 1'b0;
    end
    if (int_evt) begin
      d.int_par = 1'b1;
    end
    if (io_par_err) begin
      d.ifc_err = 1'b1;
    end
    if (tmr_zero) begin
      d.tmr_err = 1'b1;
    end

    // Stop press or an unignored internal error ends a run.
    if (p.stop) begin
      d.run = 1'b0;
    end
    if (int_evt && !sw.ignore) begin
      d.run = 1'b0;
    end
    if (int_reenable) begin
      d.int_en = 1'b1;
    end

    // Memory access register parity indicator.
    d.par_ind = (sw.wsel == WSEL_MAR) && !(^q.wreg[WSEL_MAR]) && !p.par;

    case (q.st)
      ST_STOP: begin
        if (p.run || p.step) begin
          d.run   = p.run;
          d.fetch = 1'b1;
          d.st    = ST_ISSUE;
        end else if (p.exec) begin
          d.fetch = 1'b0;
          d.st    = ST_ISSUE;
        end else if (p.store || p.disp) begin
          d.mwe  = p.store;
          d.mdst = sw.wsel;
          d.st   = ST_MEM;
        end else begin
          // Manual alteration only while stopped; clear then set.
          if (p.wclr) begin
            d.wreg[sw.wsel] = WREG_CLR;
          end else if (p.par) begin
            d.wreg[sw.wsel][PAR_BIT] = ~^q.wreg[sw.wsel][PAR_BIT-1:0];
          end
          d.wreg[sw.wsel] = d.wreg[sw.wsel] | p.wbit;
          if (p.pcclr) begin
            d.pc = '0;
          end
          d.pc = d.pc | p.pcbit;
          if (p.irclr) begin
            d.ir = '0;
          end
          d.ir = d.ir | p.irbit;
          if (osel_ok) begin
            if (p.opclr) begin
              d.oper[sw.osel] = '0;
            end
            d.oper[sw.osel] = d.oper[sw.osel] | p.opbit;
          end
        end
      end
      ST_ISSUE: begin
        if (q.fetch && q.int_en && int_req) begin
          d.st = ST_INT;
        end else begin
          d.go = 1'b1;
          d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cpu_done) begin
          if (q.fetch) begin
            d.pc = cpu_pc_next;
            d.ir = cpu_ir_next;
          end
          if (d.run && !cpu_halt) begin
            d.st = ST_ISSUE;
          end else begin
            d.run = 1'b0;
            d.st  = ST_STOP;
          end
        end
      end
      ST_MEM: begin
        if (mem_ack) begin
          if (!q.mwe) begin
            d.wreg[q.mdst] = mem_rdata;
          end
          d.ir[WF_MSB:WF_LSB] = wfield + W_ONE;
          d.st = ST_STOP;
        end
      end
      ST_INT: begin
        if (mem_ack) begin
          d.pc     = INT_VEC;
          d.int_en = 1'b0;
          d.st     = ST_ISSUE;
        end
      end
      default: begin
        d.st = ST_STOP;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Displays and indicators.
  assign disp_word   = q.wreg[sw.wsel];
  assign disp_pc     = q.pc;
  assign disp_ir     = q.ir;
  assign disp_oper   = osel_ok ? q.oper[sw.osel] : '0;
  assign mar_par_led = q.par_ind;
  assign int_par_led = q.int_par;
  assign ifc_err_led = q.ifc_err;
  assign tmr_err_led = q.tmr_err;
  assign running     = q.run;
  assign tmr_value   = q.timer;

  // Core handshake and memory request.
  assign cpu_go      = q.go;
  assign cpu_fetch   = q.fetch;
  assign mem_o.req   = (q.st == ST_MEM) || (q.st == ST_INT);
  assign mem_o.we    = (q.st == ST_INT) || q.mwe;
  assign mem_o.addr  = (q.st == ST_INT) ? INT_SAVE : wfield;
  assign mem_o.wdata = (q.st == ST_INT) ? {~^save_word, save_word} : q.wreg[q.mdst];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence exec_start_s;
    (q.st == ST_ISSUE) && !q.fetch;
  endsequence

  sequence exec_busy_s;
    (q.st == ST_WAIT) && !q.fetch;
  endsequence

  // The attempt at the release edge still samples reset values, so it is skipped.
  timer_count_a: assert property (rst_n && !tmr_load
    |=> tmr_value == $past(tmr_value) - TMR_ONE)
    else $error("timer did not decrement");
  timer_err_a: assert property (tmr_zero |=> tmr_err_led && tmr_value == '0)
    else $error("timer zero without error");
  err_clear_a: assert property (p.eclr && !int_evt && !io_par_err && !tmr_zero
    |=> !int_par_led && !ifc_err_led && !tmr_err_led)
    else $error("error clear failed");
  word_clear_a: assert property ((q.st == ST_STOP) && p.wclr && !p.run && !p.step
    && !p.exec && !p.store && !p.disp && p.wbit == '0 |=> disp_word == WREG_CLR)
    else $error("word clear wrong");
  parity_fix_a: assert property ((q.st == ST_STOP) && p.par && !p.wclr && !p.run
    && !p.step && !p.exec && !p.store && !p.disp && p.wbit == '0
    && $stable(sw.wsel) |=> (^disp_word) && !mar_par_led)
    else $error("parity press wrong");
  exec_pc_a: assert property (exec_start_s ##1 exec_busy_s |-> $stable(disp_pc) && !running)
    else $error("execute moved counter");
  step_once_a: assert property ((q.st == ST_WAIT) && cpu_done && !d.run
    |=> ((q.st == ST_STOP) && !cpu_go) [*2])
    else $error("step ran on");
  w_incr_a: assert property ((q.st == ST_MEM) && mem_ack
    |=> wfield == $past(wfield) + W_ONE && q.st == ST_STOP)
    else $error("W field not incremented");
  int_take_a: assert property ((q.st == ST_INT) && mem_ack
    |=> disp_pc == INT_VEC && !q.int_en ##1 cpu_go)
    else $error("interrupt entry wrong");
  ignore_err_a: assert property (running && int_evt && sw.ignore && !p.stop
    && !(cpu_done && cpu_halt) |=> running)
    else $error("halted on ignored error");
  go_pulse_a: assert property (cpu_go |=> !cpu_go)
    else $error("go held");

  // Error flags, run control, memory request and interrupt blocking.
  core_flag_a: assert property (int_evt |=> int_par_led)
    else $error("internal parity flag missing");
  io_flag_a: assert property (io_par_err |=> ifc_err_led)
    else $error("interface flag missing");
  err_halt_a: assert property (running && int_evt && !sw.ignore |=> !running)
    else $error("run survived internal error");
  stop_hold_a: assert property ((q.st == ST_STOP) && !p.run && !p.step && !p.exec
    && !p.store && !p.disp |=> q.st == ST_STOP)
    else $error("left stop without a press");
  exec_go_a: assert property (exec_start_s |=> cpu_go && !cpu_fetch)
    else $error("execute did not issue");
  mem_hold_a: assert property (mem_o.req && !mem_ack
    |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
    else $error("memory request dropped");
  int_block_a: assert property ((q.st == ST_ISSUE) && !q.int_en |=> q.st != ST_INT)
    else $error("interrupt taken while blocked");

endmodule

`default_nettype wire

// >>> rtl/mpc_pkg.sv
// Constants, types and carriers shared by the maintenance panel control logic.
// Assumes one 200 MHz logic clock and a processor core on the same clock.

package mpc_pkg;

  // ****************************************************************
  // Widths and field positions
  // ****************************************************************
  localparam int WORD_W  = 33;
  localparam int PAR_BIT = 32;
  localparam int PC_W    = 16;
  localparam int IR_W    = 32;
  localparam int OPR_W   = 8;
  localparam int NOPR    = 12;
  localparam int NWREG   = 4;
  localparam int TMR_W   = 32;
  localparam int WF_LSB  = 2;
  localparam int WF_MSB  = 17;

  // ****************************************************************
  // Values
  // ****************************************************************
  localparam logic [1:0]        WSEL_MAR  = 2'h0;
  localparam logic [WORD_W-1:0] WREG_CLR  = 33'h1_0000_0000;
  localparam logic [PC_W-1:0]   INT_SAVE  = 16'h0000;
  localparam logic [PC_W-1:0]   INT_VEC   = 16'h0001;
  localparam logic [TMR_W-1:0]  TMR_ONE   = 32'h0000_0001;
  localparam logic [PC_W-1:0]   W_ONE     = 16'h0001;

  // Run control states, Gray coded along stop, issue, wait.
  typedef enum logic [2:0] {
    ST_STOP  = 3'h0,
    ST_ISSUE = 3'h1,
    ST_WAIT  = 3'h3,
    ST_MEM   = 3'h2,
    ST_INT   = 3'h6
  } mpc_st_t;

  // Panel pushbuttons, one bit per button.
  typedef struct packed {
    logic [WORD_W-1:0] wbit;
    logic [PC_W-1:0]   pcbit;
    logic [IR_W-1:0]   irbit;
    logic [OPR_W-1:0]  opbit;
    logic              wclr;
    logic              par;
    logic              store;
    logic              disp;
    logic              pcclr;
    logic              irclr;
    logic              exec;
    logic              opclr;
    logic              run;
    logic              stop;
    logic              step;
    logic              eclr;
  } mpc_btn_t;

  // Panel selector and latching switches.
  typedef struct packed {
    logic [1:0] wsel;
    logic [3:0] osel;
    logic       ignore;
  } mpc_sw_t;

  // Core memory request.
  typedef struct packed {
    logic              req;
    logic              we;
    logic [PC_W-1:0]   addr;
    logic [WORD_W-1:0] wdata;
  } mpc_mem_t;

endpackage

// >>> dv/mpc_partner.sv
// Far-side model: core memory and a processor core that runs one instruction per go.
// Assumes the panel block drives mem_o and cpu_go on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none

module mpc_partner
  import mpc_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Memory side
  input  wire mpc_mem_t          mem_o,
  output logic                   mem_ack,
  output logic [WORD_W-1:0]      mem_rdata,
  // Core side
  input  wire logic              cpu_go,
  input  wire logic              cpu_fetch,
  output logic                   cpu_done,
  output logic                   cpu_halt,
  output logic [PC_W-1:0]        cpu_pc_next,
  output logic [IR_W-1:0]        cpu_ir_next,
  // Bench control
  input  wire logic [PC_W-1:0]   pc_now,
  input  wire logic              slow,
  input  wire logic [7:0]        halt_at,
  output logic [7:0]             icnt
);
  logic [WORD_W-1:0] mem [0:63];
  logic [WORD_W-1:0] rdata_q;
  logic [2:0]        mcnt;
  logic [2:0]        ccnt;
  logic              cbusy;

  // Read data is only valid with ack; between answers the bus shows the inverse.
  assign mem_rdata   = mem_ack ? rdata_q : ~rdata_q;
  assign cpu_halt    = cpu_done && (icnt == halt_at);
  assign cpu_pc_next = pc_now + 16'h0001;
  assign cpu_ir_next = {pc_now, ~pc_now};

  // Memory answers after one or five cycles, the core after two or three.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_ack  <= 1'b0;
      rdata_q  <= '0;
      mcnt     <= 3'h0;
      ccnt     <= 3'h0;
      cbusy    <= 1'b0;
      cpu_done <= 1'b0;
      icnt     <= 8'h00;
    end else begin
      mem_ack  <= 1'b0;
      cpu_done <= 1'b0;
      if (mem_o.req && !mem_ack) begin
        if (mcnt == (slow ? 3'h4 : 3'h0)) begin
          mem_ack <= 1'b1;
          mcnt    <= 3'h0;
          rdata_q <= mem[mem_o.addr[5:0]];
          if (mem_o.we) begin
            mem[mem_o.addr[5:0]] <= mem_o.wdata;
          end
        end else begin
          mcnt <= mcnt + 3'h1;
        end
      end
      if (cpu_go) begin
        cbusy <= 1'b1;
        ccnt  <= 3'h0;
      end else if (cbusy) begin
        if (ccnt == {2'h0, slow}) begin
          cpu_done <= 1'b1;
          cbusy    <= 1'b0;
          icnt     <= icnt + 8'h01;
        end else begin
          ccnt <= ccnt + 3'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> dv/maintenance_panel_control_tb_top.sv
// Self-checking bench for the maintenance panel control block.
// Assumes the partner model stands for memory and core; the bench drives interrupts.
`timescale 1ns/1ps
`default_nettype none

module maintenance_panel_control_tb_top;
  import mpc_pkg::*;
  localparam int K_ECLR = 0, K_STEP = 1, K_STOP = 2, K_RUN = 3, K_OPCLR = 4, K_EXEC = 5;
  localparam int K_IRCLR = 6, K_PCCLR = 7, K_DISP = 8, K_STORE = 9, K_PAR = 10, K_WCLR = 11;
  logic              sys_clk, nrst, mem_ack, cpu_go, cpu_fetch, cpu_done, cpu_halt;
  logic              mar_par_led, int_par_led, ifc_err_led, tmr_err_led, running;
  logic              core_par_err, io_par_err, tmr_load, slow;
  logic              int_req, int_reenable;
  logic [15:0]       int_cause;
  mpc_btn_t          panel_btn, b;
  mpc_sw_t           panel_sw;
  mpc_mem_t          mem_o;
  logic [WORD_W-1:0] disp_word, mem_rdata, mw;
  logic [PC_W-1:0]   disp_pc, cpu_pc_next, p, wa;
  logic [IR_W-1:0]   disp_ir, cpu_ir_next, w;
  logic [OPR_W-1:0]  disp_oper, v;
  logic [TMR_W-1:0]  tmr_din, tmr_value, t;
  logic [7:0]        halt_at, icnt, n;
  int                mismatches, compares, seed;

  mpc_panel uut (.sys_clk(sys_clk), .nrst(nrst), .panel_btn(panel_btn), .panel_sw(panel_sw),
    .disp_word(disp_word), .disp_pc(disp_pc), .disp_ir(disp_ir), .disp_oper(disp_oper),
    .mar_par_led(mar_par_led), .int_par_led(int_par_led), .ifc_err_led(ifc_err_led),
    .tmr_err_led(tmr_err_led), .running(running), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cpu_go(cpu_go), .cpu_fetch(cpu_fetch), .cpu_done(cpu_done),
    .cpu_halt(cpu_halt), .cpu_pc_next(cpu_pc_next), .cpu_ir_next(cpu_ir_next),
    .core_par_err(core_par_err), .io_par_err(io_par_err), .int_req(int_req),
    .int_cause(int_cause), .int_reenable(int_reenable), .tmr_load(tmr_load), .tmr_din(tmr_din),
    .tmr_value(tmr_value));

  mpc_partner u_part (.sys_clk(sys_clk), .nrst(nrst), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cpu_go(cpu_go), .cpu_fetch(cpu_fetch), .cpu_done(cpu_done),
    .cpu_halt(cpu_halt), .cpu_pc_next(cpu_pc_next), .cpu_ir_next(cpu_ir_next),
    .pc_now(disp_pc), .slow(slow), .halt_at(halt_at), .icnt(icnt));

  // ****************************************************************
  // Clock, helpers and verdict
  // ****************************************************************
  // The 200 MHz clock toggles every 2.5 ns.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // A hung run is cut short here.
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end

  // Odd parity word that a parity press must produce.
  function automatic logic [WORD_W-1:0] odd_word(input logic [IR_W-1:0] d);
    return {~^d, d};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A press holds the pins two cycles, then leaves time for any memory cycle.
  task automatic pressb(input mpc_btn_t x);
    @(negedge sys_clk) panel_btn = x;
    repeat (2) @(negedge sys_clk);
    panel_btn = '0;
    repeat (24) @(negedge sys_clk);
  endtask

  task automatic press(input int k);
    pressb(mpc_btn_t'(101'h1 << k));
  endtask

  task automatic wait_stop();
    for (int i = 0; i < 400 && running !== 1'b0; i++) @(negedge sys_clk);
    if (running !== 1'b0) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'hcad8115e;
    nrst = 1'b0;
    {panel_btn, panel_sw, core_par_err, io_par_err, tmr_load, tmr_din, slow} = '0;
    {int_req, int_cause, int_reenable} = '0;
    halt_at = 8'hff;
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Timer counts down each clock, can be preset, and flags reaching zero.
    t = tmr_value;
    repeat (10) @(negedge sys_clk);
    chk("timer", t - 32'ha, tmr_value);
    tmr_din = 32'h0000_0005;
    tmr_load = 1'b1;
    @(negedge sys_clk) tmr_load = 1'b0;
    chk("preset", 33'h5, tmr_value);
    repeat (7) @(negedge sys_clk);
    chk("tmr_err", 33'h1, tmr_err_led);
    core_par_err = 1'b1;
    io_par_err = 1'b1;
    @(negedge sys_clk) {core_par_err, io_par_err} = 2'h0;
    @(negedge sys_clk) chk("int_par", 33'h1, int_par_led);
    chk("ifc_err", 33'h1, ifc_err_led);
    press(K_ECLR);
    chk("eclr", 33'h0, {int_par_led, ifc_err_led, tmr_err_led});
    $display("test errors done");
    // Word register clear, manual bits, parity indicator and parity press.
    panel_sw.wsel = WSEL_MAR;
    press(K_WCLR);
    chk("wclr", WREG_CLR, disp_word);
    w = $random(seed);
    b = '0;
    b.wbit = {1'b0, w};
    pressb(b);
    chk("wbits", {1'b1, w}, disp_word);
    chk("mar_led", 33'(~^{1'b1, w}), mar_par_led);
    press(K_PAR);
    mw = odd_word(w);
    chk("parity", mw, disp_word);
    chk("led_off", 33'h0, mar_par_led);
    $display("test word done");
    // Store at W with a slow memory, then display it back into R.
    press(K_IRCLR);
    chk("irclr", 33'h0, disp_ir);
    wa = 16'($unsigned($random(seed)) % 62);
    b = '0;
    b.irbit = 32'(wa) << WF_LSB;
    pressb(b);
    chk("irbits", 33'(wa) << WF_LSB, disp_ir);
    slow = 1'b1;
    press(K_STORE);
    chk("store_mem", mw, u_part.mem[wa[5:0]]);
    chk("store_w", 33'(wa + 16'h1), disp_ir[WF_MSB:WF_LSB]);
    slow = 1'b0;
    press(K_IRCLR);
    pressb(b);
    panel_sw.wsel = 2'h2;
    press(K_WCLR);
    press(K_DISP);
    chk("disp_word", mw, disp_word);
    chk("disp_w", 33'(wa + 16'h1), disp_ir[WF_MSB:WF_LSB]);
    $display("test memory done");
    // Program counter and every operand item: clear, then set bits.
    press(K_PCCLR);
    chk("pcclr", 33'h0, disp_pc);
    b = '0;
    b.pcbit = 16'($random(seed));
    pressb(b);
    chk("pcbits", 33'(b.pcbit), disp_pc);
    for (int i = 0; i < 12; i++) begin
      panel_sw.osel = 4'(i);
      press(K_OPCLR);
      chk("opclr", 33'h0, disp_oper);
      v = 8'($random(seed));
      b = '0;
      b.opbit = v;
      pressb(b);
      chk("opbits", 33'(v), disp_oper);
    end
    // Selector positions past the counters show nothing.
    panel_sw.osel = 4'hc;
    repeat (4) @(negedge sys_clk);
    chk("opnone", 33'h0, disp_oper);
    $display("test operands done");
    // Step, execute, run to halt, run then stop.
    p = disp_pc;
    n = icnt;
    slow = 1'b1;
    press(K_STEP);
    chk("step_pc", 33'(p + 16'h1), disp_pc);
    chk("step_cnt", 33'(n + 8'h1), icnt);
    chk("step_run", 33'h0, running);
    press(K_EXEC);
    chk("exec_pc", 33'(p + 16'h1), disp_pc);
    chk("exec_cnt", 33'(n + 8'h2), icnt);
    chk("exec_run", 33'h0, running);
    slow = 1'b0;
    halt_at = icnt + 8'h3;
    press(K_RUN);
    wait_stop();
    chk("halt_pc", 33'(p + 16'h4), disp_pc);
    halt_at = icnt - 8'h1;
    press(K_RUN);
    chk("running", 33'h1, running);
    press(K_STOP);
    chk("stopped", 33'h0, running);
    $display("test control done");
    // Internal error ends a run unless the ignore switch is set.
    halt_at = icnt - 8'h1;
    panel_sw.ignore = 1'b1;
    press(K_RUN);
    core_par_err = 1'b1;
    @(negedge sys_clk) core_par_err = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("ignored", 33'h1, running);
    chk("err_flag", 33'h1, int_par_led);
    panel_sw.ignore = 1'b0;
    repeat (4) @(negedge sys_clk);
    core_par_err = 1'b1;
    @(negedge sys_clk) core_par_err = 1'b0;
    wait_stop();
    chk("err_stop", 33'h0, running);
    press(K_ECLR);
    $display("test error halt done");
    // A step with an interrupt pending saves counter and cause, resumes at the vector.
    int_reenable = 1'b1;
    @(negedge sys_clk) int_reenable = 1'b0;
    int_cause = 16'($random(seed));
    int_req = 1'b1;
    p = disp_pc;
    press(K_STEP);
    chk("int_save", odd_word({p, int_cause}), u_part.mem[INT_SAVE[5:0]]);
    chk("int_pc", 33'(INT_VEC + 16'h1), disp_pc);
    press(K_STEP);
    chk("int_block", 33'(INT_VEC + 16'h2), disp_pc);
    int_req = 1'b0;
    $display("test interrupt done");
    report_and_stop();
  end
endmodule

`default_nettype wire
